// [rtl/own_pkg.sv]
package own_pkg;

    // =====================================================================
    // register map
    // =====================================================================
    localparam logic [7:0]  OFS_CTRL          = 8'h00;
    localparam logic [7:0]  OFS_STATUS        = 8'h04;
    localparam logic [7:0]  OFS_LSWM          = 8'h08;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK         = 32'h000F_FFFF;
    localparam logic [31:0] LSWM_RESET        = 32'h0000_0000;

    // =====================================================================
    // control and local-store write field positions
    // =====================================================================
    localparam int BIT_ENABLE   = 0;
    localparam int POS_MODE     = 1;
    localparam int BIT_FORCE    = 3;
    localparam int BIT_SRC      = 4;
    localparam int POS_OWNER    = 5;
    localparam int POS_FCOUNT   = 9;
    localparam int BIT_SFC      = 17;
    localparam int BIT_DFC      = 18;
    localparam int BIT_OVR      = 19;
    localparam int BIT_LS_WRITE = 0;

    // =====================================================================
    // compare modes
    // =====================================================================
    localparam logic [1:0] MODE_ALWAYS = 2'h0;
    localparam logic [1:0] MODE_NEVER  = 2'h1;
    localparam logic [1:0] MODE_EQ     = 2'h2;
    localparam logic [1:0] MODE_NE     = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // fragment with the stored per-pixel owner data fetched for it
    typedef struct packed {
        logic       valid;
        logic [3:0] pix_owner_id;
        logic [7:0] pix_frame_count;
        logic       stencil_pass;
        logic       depth_pass;
    } frag_t;

    // decisions that leave with the fragment
    typedef struct packed {
        logic valid;
        logic draw;
        logic ls_write;
        logic stencil_clear;
        logic depth_clear;
    } verdict_t;

endpackage : own_pkg

// [rtl/own_judge.sv]
`timescale 1ns/1ps
module own_judge
    import own_pkg::*;
(
    input  wire logic [31:0] i_ctrl,
    input  wire logic        i_ls_write_en,
    input  wire frag_t       i_frag,
    output verdict_t         o_verdict
);
    logic       unit_en;
    logic [1:0] mode;
    logic       force_upd;
    logic [3:0] owner_id;
    logic [7:0] frame_tag_count;
    logic       own_pass;
    logic       fc_possible;

    always_comb
    begin
        unit_en         = i_ctrl[BIT_ENABLE];
        mode            = i_ctrl[POS_MODE +: 2];
        force_upd       = i_ctrl[BIT_FORCE];
        owner_id        = i_ctrl[POS_OWNER +: 4];
        frame_tag_count = i_ctrl[POS_FCOUNT +: 8];
        case (mode)
            MODE_ALWAYS: own_pass = 1'b1;
            MODE_NEVER:  own_pass = 1'b0;
            MODE_EQ:     own_pass = (owner_id == i_frag.pix_owner_id);
            MODE_NE:     own_pass = (owner_id != i_frag.pix_owner_id);
            default:     own_pass = 1'b1;
        endcase
        if (!unit_en)
        begin
            own_pass = 1'b1;
        end
        fc_possible = (frame_tag_count != i_frag.pix_frame_count);
        o_verdict.valid = i_frag.valid;
        o_verdict.draw  = i_frag.valid && own_pass;
        if (force_upd)
        begin
            o_verdict.ls_write = i_frag.valid && i_ls_write_en;
        end
        else
        begin
            o_verdict.ls_write = i_frag.valid && i_ls_write_en && own_pass
                                 && i_frag.stencil_pass && i_frag.depth_pass;
        end
        o_verdict.stencil_clear = i_frag.valid && fc_possible && i_ctrl[BIT_SFC];
        o_verdict.depth_clear   = i_frag.valid && fc_possible && i_ctrl[BIT_DFC];
    end
endmodule : own_judge

// [rtl/own_test.sv]
// Functional notes
// - with the unit disabled every fragment passes ownership regardless of mode.
// - mode 0 always passes, 1 never, 2 passes on equal ids, 3 on differing ids.
// - a fragment failing the enabled ownership test is culled and not drawn.
// - force-update writes the local store regardless of all test results and of the unit enable.
// - a forced update still needs the local-store write enable set.
// - without force, a local-store update follows the combined ownership, stencil and depth outcome.
// - the owner_id field is the reference the pixel owner is compared with.
// - frame_tag_count differing from the stored pixel count makes fast clear possible.
// - fast clear applies to stencil only with its enable set, and to depth only with its enable set.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module own_test
    import own_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    input  wire frag_t       I_FRAG,
    output verdict_t         O_VERDICT
);
    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] lswm;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        verdict_t    verdict;
        logic [15:0] drawn;
        logic [15:0] culled;
    } state_t;

    state_t   st;
    state_t   next_st;
    verdict_t judged;
    logic     take;
    logic     addr_hit;

    own_judge u_judge (
        .i_ctrl        (st.ctrl),
        .i_ls_write_en (st.lswm[BIT_LS_WRITE]),
        .i_frag        (I_FRAG),
        .o_verdict     (judged)
    );

    // =====================================================================
    // bus slave and pipeline stage
    // =====================================================================
    // zero-wait slave: reads are decoded in the address phase so data is
    // ready in the data phase without stalling the bus
    always_comb
    begin
        next_st = st;
        take    = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
        addr_hit = (I_HADDR[31:8] == 24'h00_0000);
        if (st.wr_pend)
        begin
            next_st.wr_pend = 1'b0;
            if (st.wr_addr == OFS_CTRL)
            begin
                next_st.ctrl = I_HWDATA & CTRL_MASK;
            end
            else if (st.wr_addr == OFS_LSWM)
            begin
                next_st.lswm = {31'h0, I_HWDATA[BIT_LS_WRITE]};
            end
        end
        if (take)
        begin
            // full decode: a partial one would alias the registers over the whole window
            next_st.wr_pend = I_HWRITE && addr_hit;
            next_st.wr_addr = I_HADDR[7:0];
            next_st.rdata   = 32'h0000_0000;
            if (addr_hit)
            begin
                case (I_HADDR[7:0])
                    OFS_CTRL:   next_st.rdata = st.ctrl;
                    OFS_STATUS: next_st.rdata = {st.culled, st.drawn};
                    OFS_LSWM:   next_st.rdata = st.lswm;
                    default:    next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        next_st.verdict = judged;
        if (judged.valid && judged.draw)
        begin
            next_st.drawn = st.drawn + 16'h0001;
        end
        if (judged.valid && !judged.draw)
        begin
            next_st.culled = st.culled + 16'h0001;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st      <= '0;
            st.ctrl <= CTRL_RESET;
            st.lswm <= LSWM_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign O_HRDATA    = st.rdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;
    assign O_VERDICT   = st.verdict;

    // =====================================================================
    // check helpers
    // =====================================================================
    // decoded apart from the judge so that the checks do not share its logic
    logic       unit_on;
    logic [1:0] cmp_mode;
    logic       force_on;
    logic [3:0] ref_owner;
    logic       store_wr_on;
    logic       ids_match;
    logic       counts_differ;

    assign unit_on       = st.ctrl[BIT_ENABLE];
    assign cmp_mode      = st.ctrl[POS_MODE +: 2];
    assign force_on      = st.ctrl[BIT_FORCE];
    assign ref_owner     = st.ctrl[POS_OWNER +: 4];
    assign store_wr_on   = st.lswm[BIT_LS_WRITE];
    assign ids_match     = (I_FRAG.pix_owner_id == ref_owner);
    assign counts_differ = (I_FRAG.pix_frame_count != st.ctrl[POS_FCOUNT +: 8]);

    // =====================================================================
    // checks
    // =====================================================================
    AST_DISABLED_PASS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !st.ctrl[BIT_ENABLE] |=> O_VERDICT.draw)
        else $error("disabled unit culled a fragment");

    AST_DISABLED_ANY_MODE: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !unit_on && cmp_mode == MODE_NEVER
        |=> O_VERDICT.valid && O_VERDICT.draw)
        else $error("disabled unit obeyed never mode");

    AST_NEVER_CULLS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && st.ctrl[BIT_ENABLE] && st.ctrl[POS_MODE +: 2] == MODE_NEVER |=> !O_VERDICT.draw)
        else $error("never mode drew a fragment");

    AST_ALWAYS_DRAWS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_ALWAYS
        |=> O_VERDICT.draw)
        else $error("always mode culled a fragment");

    AST_NE_MODE: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_NE
        |=> O_VERDICT.draw == !$past(ids_match))
        else $error("not-equal mode result wrong");

    AST_DRAW_IGNORES_DEPTH: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_ALWAYS && !I_FRAG.stencil_pass && !I_FRAG.depth_pass
        |=> O_VERDICT.draw)
        else $error("draw gated by stencil or depth result");

    AST_EQ_MODE: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && st.ctrl[BIT_ENABLE] && st.ctrl[POS_MODE +: 2] == MODE_EQ
        |=> O_VERDICT.draw == ($past(I_FRAG.pix_owner_id) == $past(st.ctrl[POS_OWNER +: 4])))
        else $error("equal mode result wrong");

    AST_STORED_OWNER: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_NE && ids_match
        |=> !O_VERDICT.draw)
        else $error("not-equal mode drew a matching pixel");

    AST_OWNER_REF: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_EQ && ids_match
        |=> O_VERDICT.draw)
        else $error("matching owner id culled");

    AST_OWNER_FIELD: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_NE && ref_owner != I_FRAG.pix_owner_id
        |=> O_VERDICT.draw)
        else $error("differing owner id culled");

    AST_CULL_NO_DRAW: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_EQ && !ids_match
        |=> O_VERDICT.valid && !O_VERDICT.draw)
        else $error("failing fragment was drawn");

    AST_IDLE_NO_VERDICT: assert property (@(posedge I_CLK) disable iff (I_RST)
        !I_FRAG.valid
        |=> !O_VERDICT.valid && !O_VERDICT.draw && !O_VERDICT.ls_write
            && !O_VERDICT.stencil_clear && !O_VERDICT.depth_clear)
        else $error("verdict without fragment");

    AST_VERDICT_FOLLOWS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid
        |=> O_VERDICT.valid)
        else $error("fragment lost in the stage");

    AST_CULL_COUNTED: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && unit_on && cmp_mode == MODE_NEVER
        |=> st.culled == $past(st.culled) + 16'h0001)
        else $error("culled fragment not counted");

    AST_COUNTS_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
        !I_FRAG.valid
        |=> $stable(st.drawn) && $stable(st.culled))
        else $error("counters moved without a fragment");

    // =====================================================================
    // local store update
    // =====================================================================
    AST_FORCE: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && st.ctrl[BIT_FORCE] && st.lswm[BIT_LS_WRITE] |=> O_VERDICT.ls_write)
        else $error("forced update missing");

    AST_FORCE_NEVER: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && force_on && store_wr_on && unit_on && cmp_mode == MODE_NEVER
        |=> O_VERDICT.ls_write && !O_VERDICT.draw)
        else $error("force did not override never mode");

    AST_FORCE_FAILED_TESTS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && force_on && store_wr_on && !I_FRAG.stencil_pass && !I_FRAG.depth_pass
        |=> O_VERDICT.ls_write)
        else $error("force did not override failed tests");

    AST_FORCE_GATED: assert property (@(posedge I_CLK) disable iff (I_RST)
        !st.lswm[BIT_LS_WRITE] |=> !O_VERDICT.ls_write)
        else $error("update with writes disabled");

    AST_FORCE_OFF_WRITES: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && force_on && !store_wr_on
        |=> O_VERDICT.valid && !O_VERDICT.ls_write)
        else $error("forced update with writes disabled");

    AST_NOFORCE: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !st.ctrl[BIT_FORCE] && !I_FRAG.depth_pass |=> !O_VERDICT.ls_write)
        else $error("update despite failed depth");

    AST_NOFORCE_STENCIL: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !force_on && !I_FRAG.stencil_pass
        |=> !O_VERDICT.ls_write)
        else $error("update despite failed stencil");

    AST_NOFORCE_OWNER: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !force_on && unit_on && cmp_mode == MODE_NEVER
        |=> !O_VERDICT.ls_write)
        else $error("update despite failed ownership");

    AST_NOFORCE_ALL_PASS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !force_on && store_wr_on && I_FRAG.stencil_pass && I_FRAG.depth_pass
        && (!unit_on || cmp_mode == MODE_ALWAYS)
        |=> O_VERDICT.ls_write)
        else $error("passing fragment not written");

    // =====================================================================
    // fast clear
    // =====================================================================
    AST_FAST_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid |=> O_VERDICT.depth_clear ==
        ($past(st.ctrl[BIT_DFC]) && $past(I_FRAG.pix_frame_count) != $past(st.ctrl[POS_FCOUNT +: 8])))
        else $error("depth fast clear wrong");

    AST_STENCIL_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid
        |=> O_VERDICT.stencil_clear == ($past(st.ctrl[BIT_SFC]) && $past(counts_differ)))
        else $error("stencil fast clear wrong");

    AST_CLEAR_ENABLES_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !st.ctrl[BIT_SFC] && !st.ctrl[BIT_DFC]
        |=> !O_VERDICT.stencil_clear && !O_VERDICT.depth_clear)
        else $error("fast clear with enables off");

    AST_SAME_COUNT_NO_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && !counts_differ
        |=> !O_VERDICT.stencil_clear && !O_VERDICT.depth_clear)
        else $error("fast clear on equal frame counts");

    AST_COUNT_DIFF_CLEARS: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_FRAG.valid && counts_differ && st.ctrl[BIT_SFC] && st.ctrl[BIT_DFC]
        |=> O_VERDICT.stencil_clear && O_VERDICT.depth_clear)
        else $error("fast clear missing on differing counts");

    // =====================================================================
    // register bus
    // =====================================================================
    AST_CTRL_WRITE: assert property (@(posedge I_CLK) disable iff (I_RST)
        st.wr_pend && st.wr_addr == OFS_CTRL |=> st.ctrl == ($past(I_HWDATA) & CTRL_MASK))
        else $error("control write lost");

    AST_LSWM_WRITE: assert property (@(posedge I_CLK) disable iff (I_RST)
        st.wr_pend && st.wr_addr == OFS_LSWM
        |=> st.lswm[BIT_LS_WRITE] == $past(I_HWDATA[BIT_LS_WRITE]))
        else $error("write enable setting lost");

    AST_CTRL_READ: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ && !I_HWRITE && I_HADDR == {24'h00_0000, OFS_CTRL}
        |=> O_HRDATA == $past(st.ctrl))
        else $error("control read returned wrong value");

    AST_STATUS_READ: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ && !I_HWRITE && I_HADDR == {24'h00_0000, OFS_STATUS}
        |=> O_HRDATA == $past({st.culled, st.drawn}))
        else $error("status read returned wrong value");
endmodule : own_test

// [verification/own_store.sv]
`timescale 1ns/1ps
module own_store
(
    input  wire logic [3:0] i_addr,
    output logic      [3:0] o_owner,
    output logic      [7:0] o_count
);
    // =========================================================
    // stored owner and frame tag, read with no latency
    // =========================================================
    // pattern keyed to the pixel address so every row knows its expectation
    assign o_owner = i_addr;
    assign o_count = {4'h0, i_addr};
endmodule : own_store

// [verification/pixel_ownership_test_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pixel_ownership_test_tb
    import own_pkg::*;
;
    typedef struct packed {
        logic [31:0] ctrl;
        logic        lswm;
        logic [3:0]  addr;
        logic [1:0]  sd;
        logic [3:0]  exp;
    } row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        fv = 1'b0;
    logic [3:0]  pa = 4'h0;
    logic [1:0]  sd = 2'h3;
    logic [3:0]  st_owner;
    logic [7:0]  st_count;
    frag_t       frag;
    verdict_t    verdict;
    logic [31:0] rd;
    int          n_fail = 0;
    int          n_compared = 0;
    row_t rows [16] = '{
        '{32'h0000_0AA2, 1'h1, 4'h6, 2'h3, 4'hC}, '{32'h0000_0AA1, 1'h1, 4'h6, 2'h3, 4'hC},
        '{32'h0000_0AA3, 1'h1, 4'h5, 2'h3, 4'h0}, '{32'h0000_0AA5, 1'h1, 4'h5, 2'h3, 4'hC},
        '{32'h0000_0AA5, 1'h1, 4'h6, 2'h3, 4'h0}, '{32'h0000_0AA7, 1'h1, 4'h6, 2'h3, 4'hC},
        '{32'h0000_0AA7, 1'h1, 4'h5, 2'h3, 4'h0}, '{32'h0000_0AAB, 1'h1, 4'h6, 2'h3, 4'h4},
        '{32'h0000_0AAB, 1'h0, 4'h6, 2'h3, 4'h0}, '{32'h0000_0AA1, 1'h1, 4'h5, 2'h2, 4'h8},
        '{32'h0000_0AA1, 1'h1, 4'h5, 2'h1, 4'h8}, '{32'h0000_0AA9, 1'h1, 4'h5, 2'h0, 4'hC},
        '{32'h0002_0AA1, 1'h1, 4'h6, 2'h3, 4'hE}, '{32'h0004_0AA1, 1'h1, 4'h6, 2'h3, 4'hD},
        '{32'h0006_0AA1, 1'h1, 4'h5, 2'h3, 4'hC}, '{32'h0006_0AA1, 1'h1, 4'h6, 2'h3, 4'hF}};

    always #2 clk = ~clk;
    assign frag = {fv, st_owner, st_count, sd};

    own_store i_store (.i_addr(pa), .o_owner(st_owner), .o_count(st_count));
    own_test i_dut (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(HSIZE_WORD), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_FRAG(frag), .O_VERDICT(verdict));

    // =========================================================
    // bus and closing tasks
    // =========================================================
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // =========================================================
    // sequence
    // =========================================================
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(verdict.valid, 1'b0)
        `CHK(hresp, 1'b0)
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        `CHK(rd, CTRL_RESET)
        bus(1'b0, OFS_LSWM, 32'h0, rd);
        `CHK(rd, LSWM_RESET)
        bus(1'b0, 32'h0000_000C, 32'h0, rd);
        `CHK(rd, 32'h0)
        bus(1'b1, OFS_CTRL, 32'hFFFF_FFFF, rd);
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        `CHK(rd, CTRL_MASK)
        bus(1'b0, 32'h0000_0100, 32'h0, rd);
        `CHK(rd, 32'h0)
        foreach (rows[i])
        begin
            bus(1'b1, OFS_CTRL, rows[i].ctrl, rd);
            bus(1'b1, OFS_LSWM, {31'h0, rows[i].lswm}, rd);
            fv <= 1'b1;
            pa <= rows[i].addr;
            sd <= rows[i].sd;
            @(posedge clk);
            fv <= 1'b0;
            @(posedge clk);
            `CHK(verdict.valid, 1'b1)
            `CHK(verdict.draw, rows[i].exp[3])
            `CHK({verdict.ls_write, verdict.stencil_clear, verdict.depth_clear}, rows[i].exp[2:0])
        end
        // back-to-back fragments, equal then differing owner
        bus(1'b1, OFS_CTRL, 32'h0000_0AA5, rd);
        fv <= 1'b1;
        pa <= 4'h5;
        sd <= 2'h3;
        @(posedge clk);
        pa <= 4'h6;
        @(posedge clk);
        fv <= 1'b0;
        `CHK(verdict.draw, 1'b1)
        @(posedge clk);
        `CHK(verdict.draw, 1'b0)
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd, 32'h0006_000C)
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        `CHK(rd, CTRL_RESET)
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd, 32'h0)
        print_verdict();
    end

    initial
    begin
        #40000;
        n_fail++;
        print_verdict();
    end
endmodule : pixel_ownership_test_tb
